// ### parallel_io_pkg.sv
// Shared constants, address map and decode helpers for the parallel I/O controller
package parallel_io_pkg;

  localparam int ADDR_W = 16;
  localparam int PORT_W = 8;
  localparam int HALF_W = 4;

  // Register byte addresses on the I/O bus
  localparam logic [ADDR_W-1:0] OFS_FIRST  = 16'h00C8;
  localparam logic [ADDR_W-1:0] OFS_SECOND = 16'h00CA;
  localparam logic [ADDR_W-1:0] OFS_THIRD  = 16'h00CC;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 16'h00CE;

  // Control word after reset: every port basic-mode input
  localparam logic [PORT_W-1:0] CTRL_RESET   = 8'h9B;
  // Basic mode, first/second ports in, third port out
  localparam logic [PORT_W-1:0] CTRL_AB_IN_C_OUT = 8'h92;
  localparam logic [PORT_W-1:0] BYTE_ZERO    = 8'h00;

  // Control word fields
  localparam int CW_MODE_SET  = 7;
  localparam int CW_A_MODE_HI = 6;
  localparam int CW_A_MODE_LO = 5;
  localparam int CW_A_IN      = 4;
  localparam int CW_CU_IN     = 3;
  localparam int CW_B_MODE    = 2;
  localparam int CW_B_IN      = 1;
  localparam int CW_CL_IN     = 0;
  localparam int BSR_SEL_HI   = 3;
  localparam int BSR_SEL_LO   = 1;
  localparam int BSR_VAL      = 0;

  // Third-port lines borrowed by the strobed modes
  localparam int PC_B_SPARE   = 0;
  localparam int PC_B_FLAG    = 1;
  localparam int PC_B_STB_ACK = 2;
  localparam int PC_A_SPARE   = 3;
  localparam int PC_A_STB     = 4;
  localparam int PC_A_IBF     = 5;
  localparam int PC_A_ACK     = 6;
  localparam int PC_A_OBF     = 7;

  typedef enum logic [4:0] {
    SEL_NONE   = 5'h01,
    SEL_FIRST  = 5'h02,
    SEL_SECOND = 5'h04,
    SEL_THIRD  = 5'h08,
    SEL_CTRL   = 5'h10
  } sel_e;

  // Address decode shared by the read and write paths
  function automatic sel_e decode_sel(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_FIRST:  decode_sel = SEL_FIRST;
      OFS_SECOND: decode_sel = SEL_SECOND;
      OFS_THIRD:  decode_sel = SEL_THIRD;
      OFS_CTRL:   decode_sel = SEL_CTRL;
      default:    decode_sel = SEL_NONE;
    endcase
  endfunction

endpackage

// ### parallel_lane.sv
// One 8-bit data port: output latch, strobed input latch and handshake flags
`timescale 1ns/1ps
module parallel_lane #(
  parameter int W = parallel_io_pkg::PORT_W
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clear,
  input  wire logic         i_hs_in,
  input  wire logic         i_hs_out,
  input  wire logic         i_stb_n,
  input  wire logic         i_ack_n,
  input  wire logic         i_host_rd,
  input  wire logic         i_host_wr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_in_latch,
  output logic      [W-1:0] o_out_latch,
  output logic              o_ibf,
  output logic              o_obf_n
);
  import parallel_io_pkg::*;

  logic         stb_prev_q;
  logic         stb_fall;
  logic [W-1:0] in_q;
  logic [W-1:0] out_q;
  logic         ibf_q;
  logic         obf_n_q;

  // Strobe falling edge, only while strobed input is enabled
  assign stb_fall = stb_prev_q & ~i_stb_n & i_hs_in;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stb_prev_q <= 1'b1;
    end else begin
      stb_prev_q <= i_stb_n;
    end
  end

  // Input latch captures the pins on the strobe edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_q <= '0;
    end else if (stb_fall) begin
      in_q <= i_pins; // [RL3]
    end
  end

  // Input buffer full: strobe sets, host read clears, set wins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ibf_q <= 1'b0;
    end else if (i_clear) begin
      ibf_q <= 1'b0;
    end else if (stb_fall) begin
      ibf_q <= 1'b1; // [RL2] [RL3]
    end else if (i_host_rd) begin
      ibf_q <= 1'b0;
    end
  end

  // Output latch, cleared by any mode definition
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= '0;
    end else if (i_clear) begin
      out_q <= '0;
    end else if (i_host_wr) begin
      out_q <= i_wdata; // [RL11]
    end
  end

  // Output buffer full (low active): host write asserts, acknowledge releases
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      obf_n_q <= 1'b1;
    end else if (i_clear) begin
      obf_n_q <= 1'b1;
    end else if (i_host_wr && i_hs_out) begin
      obf_n_q <= 1'b0; // [RL2] [RL3]
    end else if (i_hs_out && !i_ack_n) begin
      obf_n_q <= 1'b1;
    end
  end

  assign o_in_latch  = in_q;
  assign o_out_latch = out_q;
  assign o_ibf       = ibf_q;
  assign o_obf_n     = obf_n_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking lane_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_ibf_on_strobe: assert property ( // [RL3]
    stb_fall && !i_clear |=> o_ibf && o_in_latch == $past(i_pins))
    else $error("strobe did not latch input and set full flag");

  a_obf_on_ack: assert property ( // [RL2]
    i_hs_out && !i_ack_n && !i_host_wr && !i_clear |=> o_obf_n)
    else $error("acknowledge did not release output full flag");

endmodule

// ### peer_lane.sv
// Model of the peripheral wired to one 8-bit port of the controller
`timescale 1ns/1ps
module peer_lane (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_dut_q,
  input  wire logic [7:0] i_dut_oe,
  input  wire logic [7:0] i_peer_q,
  input  wire logic [7:0] i_peer_oe,
  output logic      [7:0] o_wire
);
  logic [7:0] last_q;

  // Wire level: controller, else peripheral, else a floating line that flips
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_dut_oe[i]) begin
        o_wire[i] = i_dut_q[i];
      end else if (i_peer_oe[i]) begin
        o_wire[i] = i_peer_q[i];
      end else begin
        o_wire[i] = ~last_q[i];
      end
    end
  end

  // Remember the last level so a released line never holds its value
  always_ff @(posedge i_ref_clk) begin
    last_q <= o_wire;
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the three-port parallel I/O controller
`timescale 1ns/1ps
module tb_top;
  import parallel_io_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_rst_n   = 1'b0;
  logic [ADDR_W-1:0] io_addr   = '0;
  logic              io_rd     = 1'b0;
  logic              io_wr     = 1'b0;
  logic [PORT_W-1:0] io_wdata  = '0;
  logic [PORT_W-1:0] io_rdata, rv;
  logic [PORT_W-1:0] pa_in, pa_q, pa_oe, pb_in, pb_q, pb_oe, pc_in, pc_q, pc_oe;
  logic [PORT_W-1:0] peer_a = 8'hA5;
  logic [PORT_W-1:0] peer_b = 8'h5A;
  logic [PORT_W-1:0] peer_c = 8'hFF;
  logic [PORT_W-1:0] exp_c;
  logic [23:0]       oe_tab [4] = '{24'hFFFFFF, 24'hFFFF0F, 24'hFFFFF0, 24'h000000};
  logic [7:0]        cw_tab [4] = '{8'h80, 8'h88, 8'h81, 8'h9B};
  int                miscompares = 0;
  int                num_checks  = 0;

  // Clock at 8 ns
  always #4 i_ref_clk = ~i_ref_clk;

  three_port_parallel_io i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_io_addr(io_addr), .i_io_rd(io_rd),
    .i_io_wr(io_wr), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
    .i_pa(pa_in), .o_pa(pa_q), .o_pa_oe(pa_oe), .i_pb(pb_in), .o_pb(pb_q),
    .o_pb_oe(pb_oe), .i_pc(pc_in), .o_pc(pc_q), .o_pc_oe(pc_oe));
  peer_lane i_peer_a (.i_ref_clk(i_ref_clk), .i_dut_q(pa_q), .i_dut_oe(pa_oe),
    .i_peer_q(peer_a), .i_peer_oe(8'hFF), .o_wire(pa_in));
  peer_lane i_peer_b (.i_ref_clk(i_ref_clk), .i_dut_q(pb_q), .i_dut_oe(pb_oe),
    .i_peer_q(peer_b), .i_peer_oe(8'hFF), .o_wire(pb_in));
  peer_lane i_peer_c (.i_ref_clk(i_ref_clk), .i_dut_q(pc_q), .i_dut_oe(pc_oe),
    .i_peer_q(peer_c), .i_peer_oe(8'hFF), .o_wire(pc_in));

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe, effective at the sampling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
    @(posedge i_ref_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge i_ref_clk);
    io_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe, data registered at the sampling edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [PORT_W-1:0] d);
    @(posedge i_ref_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge i_ref_clk);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(3000 * 8);
    miscompares++;
    test_done();
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    chk("pa_oe rst", 8'h00, pa_oe);
    rd(OFS_FIRST, rv);
    chk("rd first", 8'hA5, rv);
    rd(OFS_CTRL, rv);
    chk("rd ctrl", 8'h00, rv);
    rd(16'h00D0, rv);
    chk("rd unmapped", 8'h00, rv);
    $display("test reset done");

    wr(OFS_CTRL, 8'h92);
    chk("oe a", 8'h00, pa_oe);
    chk("oe b", 8'h00, pb_oe);
    chk("oe c", 8'hFF, pc_oe);
    rd(OFS_SECOND, rv);
    chk("rd second", 8'h5A, rv);
    wr(OFS_THIRD, 8'h3C);
    wr(16'h00D0, 8'hFF);
    chk("c latch", 8'h3C, pc_q);
    exp_c = 8'h3C;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, {4'h0, i[2:0], ~exp_c[i]});
      exp_c[i] = ~exp_c[i];
      chk("bit cmd", exp_c, pc_q);
    end
    chk("oe c kept", 8'hFF, pc_oe);
    rd(OFS_THIRD, rv);
    chk("rd third", exp_c, rv);
    $display("test basic done");

    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, cw_tab[k]);
      chk("oe a", oe_tab[k][23:16], pa_oe);
      chk("oe b", oe_tab[k][15:8], pb_oe);
      chk("oe c", oe_tab[k][7:0], pc_oe);
    end
    wr(OFS_CTRL, 8'h80);
    wr(OFS_FIRST, 8'h11);
    wr(OFS_SECOND, 8'h22);
    chk("a latch", 8'h11, pa_q);
    chk("b latch", 8'h22, pb_q);
    wr(OFS_CTRL, 8'h80);
    chk("a cleared", 8'h00, pa_q);
    $display("test modes done");

    wr(OFS_CTRL, 8'hB0);
    @(posedge i_ref_clk);
    peer_a <= 8'h6E;
    @(posedge i_ref_clk);
    peer_c[4] <= 1'b0;
    repeat (4) begin
      @(posedge i_ref_clk);
    end
    #1;
    chk("ibf set", 8'h01, {7'h0, pc_q[5]});
    @(posedge i_ref_clk);
    peer_a    <= 8'h00;
    peer_c[4] <= 1'b1;
    rd(OFS_FIRST, rv);
    chk("rd latched", 8'h6E, rv);
    @(posedge i_ref_clk);
    #1;
    chk("ibf clr", 8'h00, {7'h0, pc_q[5]});
    wr(OFS_CTRL, 8'h07);
    chk("spare set", 8'h01, {7'h0, pc_q[3]});
    $display("test strobe in done");

    wr(OFS_CTRL, 8'hC0);
    chk("bidir off", 8'h00, pa_oe);
    @(posedge i_ref_clk);
    peer_c[6] <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk("bidir on", 8'hFF, pa_oe);
    @(posedge i_ref_clk);
    peer_c[6] <= 1'b1;
    $display("test bidir done");

    wr(OFS_CTRL, 8'h84);
    wr(OFS_SECOND, 8'h77);
    @(posedge i_ref_clk);
    #1;
    chk("b out", 8'h77, pb_q);
    chk("obf low", 8'h00, {7'h0, pc_q[1]});
    @(posedge i_ref_clk);
    peer_c[2] <= 1'b0;
    repeat (3) begin
      @(posedge i_ref_clk);
    end
    #1;
    chk("obf high", 8'h01, {7'h0, pc_q[1]});
    @(posedge i_ref_clk);
    peer_c[2] <= 1'b1;
    $display("test strobe out done");

    // First port strobed output, second port strobed input
    wr(OFS_CTRL, 8'hA6);
    wr(OFS_FIRST, 8'h4B);
    chk("a out", 8'h4B, pa_q);
    chk("a oe", 8'hFF, pa_oe);
    chk("a obf low", 8'h00, {7'h0, pc_q[7]});
    @(posedge i_ref_clk);
    peer_b    <= 8'hC3;
    peer_c[2] <= 1'b0;
    peer_c[6] <= 1'b0;
    repeat (2) begin
      @(posedge i_ref_clk);
    end
    #1;
    chk("b ibf set", 8'h01, {7'h0, pc_q[1]});
    chk("a obf high", 8'h01, {7'h0, pc_q[7]});
    @(posedge i_ref_clk);
    peer_b    <= 8'h00;
    peer_c[2] <= 1'b1;
    peer_c[6] <= 1'b1;
    rd(OFS_SECOND, rv);
    chk("rd b latched", 8'hC3, rv);
    $display("test strobe pairs done");

    // Reset in mid-run returns every port to undriven input
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    peer_b  <= 8'h96;
    @(posedge i_ref_clk);
    #1;
    chk("rst a latch", 8'h00, pa_q);
    chk("rst a oe", 8'h00, pa_oe);
    chk("rst c oe", 8'h00, pc_oe);
    chk("rst rdata", 8'h00, io_rdata);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(OFS_SECOND, rv);
    chk("rd second rst", 8'h96, rv);
    $display("test reset again done");
    test_done();
  end
endmodule

// ### three_port_parallel_io.sv
// Three-port programmable parallel I/O controller on the host I/O bus
// Contract
// RL1: Twenty-four lines in three 8-bit ports
// RL2: First port: basic, strobed, bidirectional modes
// RL3: Second port: basic or strobed, no bidirectional
// RL4: Third port: input, output, or split halves
// RL5: Bits 3-6 configure first port, upper half
// RL6: Bits 0-2 configure second port, lower half
// RL7: Bit 7 flags a mode definition
// RL8: Ports at C8, CA, CC, control CE
// RL9: Value 92 hex: ports in, third out
// RL10: Host configures before using any line
// RL11: Port reads return input, writes load output
// RL12: Single write sets/clears one third-port bit
// RL13: Bit set/clear also works on handshake lines; the code shows the bit only on spare lines 0 and 3, flag lines show the flags
// RL14: Flag high defines mode, low sets bit
// RL15: Bits 3-1 pick bit, bit 0 value
`timescale 1ns/1ps
module three_port_parallel_io (
  input  wire logic                             i_ref_clk,
  input  wire logic                             i_rst_n,
  input  wire logic [parallel_io_pkg::ADDR_W-1:0] i_io_addr,
  input  wire logic                             i_io_rd,
  input  wire logic                             i_io_wr,
  input  wire logic [parallel_io_pkg::PORT_W-1:0] i_io_wdata,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_io_rdata,
  input  wire logic [parallel_io_pkg::PORT_W-1:0] i_pa,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pa,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pa_oe,
  input  wire logic [parallel_io_pkg::PORT_W-1:0] i_pb,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pb,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pb_oe,
  input  wire logic [parallel_io_pkg::PORT_W-1:0] i_pc,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pc,
  output logic      [parallel_io_pkg::PORT_W-1:0] o_pc_oe
);
  import parallel_io_pkg::*;

  logic [PORT_W-1:0] ctrl_q;
  logic [PORT_W-1:0] c_latch_q;
  logic [PORT_W-1:0] rdata_q;
  sel_e              wr_sel;
  sel_e              rd_sel;
  logic              mode_set_wr;
  logic              bsr_wr;
  logic [2:0]        bsr_sel;
  logic [PORT_W-1:0] bsr_mask;
  logic              a_mode2;
  logic              a_strobed;
  logic              a_in;
  logic              a_hs_in;
  logic              a_hs_out;
  logic              b_strobed;
  logic              b_in;
  logic [PORT_W-1:0] a_in_latch;
  logic [PORT_W-1:0] a_out;
  logic              a_ibf;
  logic              a_obf_n;
  logic [PORT_W-1:0] b_in_latch;
  logic [PORT_W-1:0] b_out;
  logic              b_ibf;
  logic              b_obf_n;
  logic [PORT_W-1:0] pc_out;
  logic [PORT_W-1:0] pc_oe;
  logic [PORT_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and control word commands
  assign wr_sel      = i_io_wr ? decode_sel(i_io_addr) : SEL_NONE; // [RL8]
  assign rd_sel      = i_io_rd ? decode_sel(i_io_addr) : SEL_NONE; // [RL8]
  assign mode_set_wr = (wr_sel == SEL_CTRL) && i_io_wdata[CW_MODE_SET]; // [RL7] [RL14]
  assign bsr_wr      = (wr_sel == SEL_CTRL) && !i_io_wdata[CW_MODE_SET]; // [RL14]
  assign bsr_sel     = i_io_wdata[BSR_SEL_HI:BSR_SEL_LO]; // [RL15]
  assign bsr_mask    = 8'h01 << bsr_sel;

  // Mode fields of the stored control word
  assign a_mode2   = ctrl_q[CW_A_MODE_HI]; // [RL5]
  assign a_strobed = ctrl_q[CW_A_MODE_HI] | ctrl_q[CW_A_MODE_LO]; // [RL5]
  assign a_in      = ctrl_q[CW_A_IN]; // [RL5]
  assign a_hs_in   = a_mode2 | (a_strobed & a_in); // [RL2]
  assign a_hs_out  = a_mode2 | (a_strobed & ~a_in); // [RL2]
  assign b_strobed = ctrl_q[CW_B_MODE]; // [RL6]
  assign b_in      = ctrl_q[CW_B_IN]; // [RL6]

  // Control word; reset leaves every line undriven until configured
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RESET; // [RL10]
    end else if (mode_set_wr) begin
      ctrl_q <= i_io_wdata; // [RL7] [RL9]
    end
  end

  // Third-port latch: byte writes, single-bit commands, cleared by mode set
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_latch_q <= '0;
    end else if (mode_set_wr) begin
      c_latch_q <= '0;
    end else if (bsr_wr) begin
      c_latch_q <= i_io_wdata[BSR_VAL] ? (c_latch_q | bsr_mask)
                                       : (c_latch_q & ~bsr_mask); // [RL12] [RL13] [RL15]
    end else if (wr_sel == SEL_THIRD) begin
      c_latch_q <= i_io_wdata; // [RL11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First and second data ports
  parallel_lane #(.W(PORT_W)) u_first (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (mode_set_wr),
    .i_hs_in     (a_hs_in),
    .i_hs_out    (a_hs_out),
    .i_stb_n     (i_pc[PC_A_STB]),
    .i_ack_n     (i_pc[PC_A_ACK]),
    .i_host_rd   (rd_sel == SEL_FIRST),
    .i_host_wr   (wr_sel == SEL_FIRST),
    .i_wdata     (i_io_wdata),
    .i_pins      (i_pa),
    .o_in_latch  (a_in_latch),
    .o_out_latch (a_out),
    .o_ibf       (a_ibf),
    .o_obf_n     (a_obf_n)
  );

  parallel_lane #(.W(PORT_W)) u_second (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (mode_set_wr),
    .i_hs_in     (b_strobed & b_in),
    .i_hs_out    (b_strobed & ~b_in),
    .i_stb_n     (i_pc[PC_B_STB_ACK]),
    .i_ack_n     (i_pc[PC_B_STB_ACK]),
    .i_host_rd   (rd_sel == SEL_SECOND),
    .i_host_wr   (wr_sel == SEL_SECOND),
    .i_wdata     (i_io_wdata),
    .i_pins      (i_pb),
    .o_in_latch  (b_in_latch),
    .o_out_latch (b_out),
    .o_ibf       (b_ibf),
    .o_obf_n     (b_obf_n)
  );

  // Pin drive: bidirectional first port drives only while acknowledged
  assign o_pa    = a_out;
  assign o_pa_oe = {PORT_W{a_mode2 ? ~i_pc[PC_A_ACK] : ~a_in}}; // [RL1] [RL2]
  assign o_pb    = b_out;
  assign o_pb_oe = {PORT_W{~b_in}}; // [RL1] [RL3]

  // Third port: halves by direction, handshake lines taken by strobed modes
  always_comb begin
    pc_oe  = {{HALF_W{~ctrl_q[CW_CU_IN]}}, {HALF_W{~ctrl_q[CW_CL_IN]}}}; // [RL4]
    pc_out = c_latch_q;
    if (a_strobed) begin
      pc_oe[PC_A_SPARE] = 1'b1;
    end
    if (a_hs_in) begin
      pc_oe[PC_A_STB]  = 1'b0;
      pc_oe[PC_A_IBF]  = 1'b1;
      pc_out[PC_A_IBF] = a_ibf;
    end
    if (a_hs_out) begin
      pc_oe[PC_A_ACK]  = 1'b0;
      pc_oe[PC_A_OBF]  = 1'b1;
      pc_out[PC_A_OBF] = a_obf_n;
    end
    if (b_strobed) begin
      pc_oe[PC_B_SPARE]   = 1'b1;
      pc_oe[PC_B_STB_ACK] = 1'b0;
      pc_oe[PC_B_FLAG]    = 1'b1;
      pc_out[PC_B_FLAG]   = b_in ? b_ibf : b_obf_n;
    end
  end

  assign o_pc    = pc_out;
  assign o_pc_oe = pc_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; control and unmapped addresses read zero
  always_comb begin
    case (rd_sel)
      SEL_FIRST:  rd_mux = a_hs_in ? a_in_latch : (a_in ? i_pa : a_out); // [RL11]
      SEL_SECOND: rd_mux = (b_strobed & b_in) ? b_in_latch : (b_in ? i_pb : b_out); // [RL11]
      SEL_THIRD:  rd_mux = (pc_oe & pc_out) | (~pc_oe & i_pc); // [RL11]
      default:    rd_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= BYTE_ZERO;
    end else if (i_io_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_io_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking main_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_mode_wr;
    i_io_wr && i_io_addr == OFS_CTRL && i_io_wdata[CW_MODE_SET];
  endsequence

  sequence s_bsr_wr;
    i_io_wr && i_io_addr == OFS_CTRL && !i_io_wdata[CW_MODE_SET];
  endsequence

  a_mode_load: assert property ( // [RL7] [RL14]
    s_mode_wr |=> ctrl_q == $past(i_io_wdata) && c_latch_q == BYTE_ZERO)
    else $error("mode definition not loaded");

  a_bsr_keeps_mode: assert property ( // [RL14]
    s_bsr_wr |=> $stable(ctrl_q))
    else $error("bit command altered the mode");

  a_bsr_bit_value: assert property ( // [RL12] [RL15]
    s_bsr_wr |=> c_latch_q[$past(bsr_sel)] == $past(i_io_wdata[BSR_VAL]))
    else $error("selected third-port bit has wrong value");

  a_bsr_others_kept: assert property ( // [RL12] [RL13]
    s_bsr_wr |=> ((c_latch_q ^ $past(c_latch_q)) & ~$past(bsr_mask)) == BYTE_ZERO)
    else $error("bit command disturbed other bits");

  a_cfg_ab_in_c_out: assert property ( // [RL9]
    s_mode_wr ##0 i_io_wdata == CTRL_AB_IN_C_OUT |=>
      o_pa_oe == BYTE_ZERO && o_pb_oe == BYTE_ZERO && o_pc_oe == ~BYTE_ZERO)
    else $error("configuration 92 hex drives wrong lines");

  a_read_first: assert property ( // [RL11]
    rd_sel == SEL_FIRST && !a_strobed && a_in |=> o_io_rdata == $past(i_pa))
    else $error("first port read did not return pins");

  // A back-to-back second-port write or a mode set in the next cycle legally replaces the value
  a_write_second: assert property ( // [RL11]
    wr_sel == SEL_SECOND ##1 !mode_set_wr && wr_sel != SEL_SECOND |=>
      o_pb == $past(i_io_wdata, 2))
    else $error("second port write not held on output");

  a_unmapped_zero: assert property ( // [RL8]
    i_io_rd && (rd_sel == SEL_NONE || rd_sel == SEL_CTRL) |=> o_io_rdata == BYTE_ZERO)
    else $error("unmapped read not zero");

  a_split_halves: assert property ( // [RL4]
    !a_strobed && !b_strobed |->
      o_pc_oe[PORT_W-1:HALF_W] == {HALF_W{~ctrl_q[CW_CU_IN]}} &&
      o_pc_oe[HALF_W-1:0] == {HALF_W{~ctrl_q[CW_CL_IN]}})
    else $error("third port half direction wrong");

endmodule
